//--- abe_sbox.sv
// Package of constants and field arithmetic for the block engine, and its byte substitution unit.
// Assumes a single synchronous clock domain; the unit is purely combinational.
`timescale 1ns/1ps

package abe_pkg;
   localparam int BYTE_W = 8;
   localparam int NBYTES = 16;
   localparam int PTR_W = 4;
   localparam int CYC_W = 9;
   localparam int PH_W = 5;
   localparam int RND_W = 4;
   // Cycles from a taken start to the result becoming readable.
   localparam logic [CYC_W-1:0] RUN_CYCLES = 9'h177;
   localparam logic [RND_W-1:0] LAST_ROUND = 4'ha;
   localparam logic [RND_W-1:0] FIRST_ROUND = 4'h1;
   localparam logic [RND_W-1:0] DEC_START_ROUND = 4'h9;
   localparam logic [PH_W-1:0] PH_KEY_LAST = 5'h03;
   localparam logic [PH_W-1:0] PH_KEXP_APPLY = 5'h04;
   localparam logic [PH_W-1:0] PH_ROUND_APPLY = 5'h10;
   localparam logic [PTR_W-1:0] PTR_LAST = 4'hf;
   localparam logic [7:0] RCON_FIRST = 8'h01;
   localparam logic [7:0] RCON_LAST = 8'h36;
   localparam logic [7:0] RCON_POLY = 8'h1b;
   localparam logic [7:0] RCON_UNDO = 8'h80;
   localparam logic [7:0] AFF_FWD = 8'h63;
   localparam logic [7:0] AFF_INV = 8'h05;
   localparam logic [7:0] INV_EXP = 8'hfe;

   typedef enum logic [1:0] {ST_IDLE, ST_KEXP, ST_ROUND, ST_WAIT} abe_state_t;

   function automatic logic [7:0] abe_xt(input logic [7:0] a);
      abe_xt = {a[6:0], 1'b0} ^ (a[7] ? RCON_POLY : 8'h00);
   endfunction

   function automatic logic [7:0] abe_gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h00;
      x = a;
      for (int i = 0; i < 8; i++)
      begin
         if (b[i])
            p = p ^ x;
         x = abe_xt(x);
      end
      abe_gmul = p;
   endfunction

   // Mixes one column; col[r] is the byte of row r.
   function automatic logic [3:0][7:0] abe_mix(input logic [3:0][7:0] col, input logic inv);
      logic [3:0][7:0] o;
      o = '0;
      for (int r = 0; r < 4; r++)
      begin
         if (inv)
            o[r] = abe_gmul(col[r], 8'h0e) ^ abe_gmul(col[(r + 1) % 4], 8'h0b)
                 ^ abe_gmul(col[(r + 2) % 4], 8'h0d) ^ abe_gmul(col[(r + 3) % 4], 8'h09);
         else
            o[r] = abe_xt(col[r]) ^ abe_xt(col[(r + 1) % 4]) ^ col[(r + 1) % 4]
                 ^ col[(r + 2) % 4] ^ col[(r + 3) % 4];
      end
      abe_mix = o;
   endfunction
endpackage

// Substitution box computed from the field inverse rather than a table, trading area for
// a short and table-free description.
module abe_sbox
(
   input wire logic inv_i,
   input wire logic [abe_pkg::BYTE_W-1:0] byte_i,
   output logic [abe_pkg::BYTE_W-1:0] byte_o
);
   import abe_pkg::*;

   function automatic logic [7:0] rotl(input logic [7:0] a, input int n);
      rotl = (a << n) | (a >> (8 - n));
   endfunction

   function automatic logic [7:0] finv(input logic [7:0] a);
      logic [7:0] r;
      logic [7:0] p;
      r = 8'h01;
      p = a;
      for (int i = 0; i < 8; i++)
      begin
         if (INV_EXP[i])
            r = abe_gmul(r, p);
         p = abe_gmul(p, p);
      end
      finv = r;
   endfunction

   logic [7:0] pre;
   logic [7:0] fin;

   always_comb
   begin
      pre = rotl(byte_i, 1) ^ rotl(byte_i, 3) ^ rotl(byte_i, 6) ^ AFF_INV;
      fin = finv(inv_i ? pre : byte_i);
      if (inv_i)
         byte_o = fin;
      else
         byte_o = fin ^ rotl(fin, 1) ^ rotl(fin, 2) ^ rotl(fin, 3) ^ rotl(fin, 4) ^ AFF_FWD;
   end
endmodule

//--- abe_engine.sv
// Block cipher engine: byte-serial key and state loading, one state byte substituted per cycle,
// fixed run length, byte-serial readout, completion request and transfer trigger.
// Assumes the control inputs come from logic on clk_sys_i; no software registers exist.
`timescale 1ns/1ps

// Overview of operation
// - 128-bit block, 128-bit key, both directions.
// - Result ready exactly 375 cycles after start.
// - Completion raises interrupt only when enabled.
// - Completion pulses a transfer trigger.
// - Auto start after last state byte written.
// - XOR load combines written byte with held byte.
module abe_engine
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic decrypt_i,
   input wire logic xor_load_i,
   input wire logic auto_start_i,
   input wire logic irq_en_i,
   input wire logic start_i,
   input wire logic key_wr_i,
   input wire logic [abe_pkg::BYTE_W-1:0] key_wdata_i,
   input wire logic st_wr_i,
   input wire logic [abe_pkg::BYTE_W-1:0] st_wdata_i,
   input wire logic st_rd_i,
   output logic [abe_pkg::BYTE_W-1:0] st_rdata_o,
   output logic busy_o,
   output logic done_o,
   output logic irq_o,
   output logic dma_trig_o
);
   import abe_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   abe_state_t fsm_q, fsm_d;
   logic [NBYTES-1:0][7:0] st_q, st_d;
   logic [NBYTES-1:0][7:0] key_q, key_d;
   logic [NBYTES-1:0][7:0] wk_q, wk_d;
   logic [3:0][7:0] sw_q, sw_d;
   logic [7:0] rcon_q, rcon_d;
   logic [PH_W-1:0] ph_q, ph_d;
   logic [RND_W-1:0] rnd_q, rnd_d;
   logic [CYC_W-1:0] cyc_q, cyc_d;
   logic [PTR_W-1:0] kptr_q, kptr_d;
   logic [PTR_W-1:0] wptr_q, wptr_d;
   logic [PTR_W-1:0] rptr_q, rptr_d;
   logic dec_q, dec_d;
   logic go_q, go_d;
   logic done_q, done_d;
   logic irq_q, irq_d;
   logic trig_q, trig_d;
   logic busy_q, busy_d;
   logic [7:0] rdata_q, rdata_d;

   logic [3:0][7:0] kin;
   logic [7:0] st_sub;
   logic [7:0] key_sub;
   logic dec_round;

   // ****************************************************************
   // Substitution units
   // ****************************************************************
   // The key schedule always runs the forward box, even while the state runs the inverse.
   always_comb
   begin
      dec_round = dec_q && (fsm_q == ST_ROUND);
      for (int r = 0; r < 4; r++)
         kin[r] = wk_q[12 + r] ^ (dec_round ? wk_q[8 + r] : 8'h00);
   end

   abe_sbox u_sbox_st
   (
      .inv_i(dec_q),
      .byte_i(st_q[ph_q[PTR_W-1:0]]),
      .byte_o(st_sub)
   );

   abe_sbox u_sbox_key
   (
      .inv_i(1'b0),
      .byte_i(kin[ph_q[1:0] + 2'd1]),
      .byte_o(key_sub)
   );

   // ****************************************************************
   // Next values
   // ****************************************************************
   always_comb
   begin
      logic [NBYTES-1:0][7:0] nk;
      logic [NBYTES-1:0][7:0] sh;
      logic [7:0] rc_step;
      logic run_go;
      nk = '0;
      sh = '0;
      rc_step = 8'h00;
      run_go = 1'b0;
      fsm_d = fsm_q;
      st_d = st_q;
      key_d = key_q;
      wk_d = wk_q;
      sw_d = sw_q;
      rcon_d = rcon_q;
      ph_d = ph_q;
      rnd_d = rnd_q;
      cyc_d = cyc_q;
      kptr_d = kptr_q;
      wptr_d = wptr_q;
      rptr_d = rptr_q;
      dec_d = dec_q;
      go_d = 1'b0;
      done_d = done_q;
      irq_d = irq_q;
      trig_d = 1'b0;
      rdata_d = rdata_q;

      // Key step: forward during encryption and expansion, backward during decrypt rounds.
      for (int r = 0; r < 4; r++)
      begin
         if (dec_round)
         begin
            nk[12 + r] = wk_q[12 + r] ^ wk_q[8 + r];
            nk[8 + r] = wk_q[8 + r] ^ wk_q[4 + r];
            nk[4 + r] = wk_q[4 + r] ^ wk_q[r];
            nk[r] = wk_q[r] ^ sw_q[r] ^ ((r == 0) ? rcon_q : 8'h00);
         end
         else
         begin
            nk[r] = wk_q[r] ^ sw_q[r] ^ ((r == 0) ? rcon_q : 8'h00);
            nk[4 + r] = wk_q[4 + r] ^ nk[r];
            nk[8 + r] = wk_q[8 + r] ^ nk[4 + r];
            nk[12 + r] = wk_q[12 + r] ^ nk[8 + r];
         end
      end
      if (dec_round)
         rc_step = rcon_q[0] ? (((rcon_q ^ RCON_POLY) >> 1) | RCON_UNDO) : (rcon_q >> 1);
      else
         rc_step = abe_xt(rcon_q);

      // Row shift; byte index is row + 4 * column.
      for (int c = 0; c < 4; c++)
         for (int r = 0; r < 4; r++)
            sh[r + 4 * c] = dec_q ? st_q[r + 4 * ((c - r + 4) % 4)] : st_q[r + 4 * ((c + r) % 4)];

      unique case (fsm_q)
         ST_IDLE:
         begin
            if (key_wr_i)
            begin
               key_d[kptr_q] = key_wdata_i;
               kptr_d = kptr_q + 1'b1;
            end
            if (st_wr_i)
            begin
               st_d[wptr_q] = xor_load_i ? (st_q[wptr_q] ^ st_wdata_i) : st_wdata_i;
               wptr_d = wptr_q + 1'b1;
               go_d = auto_start_i && (wptr_q == PTR_LAST);
            end
            if (st_rd_i && done_q)
            begin
               rdata_d = st_q[rptr_q];
               rptr_d = rptr_q + 1'b1;
            end
            // A load in the start cycle wins; the start is not taken and is not held for later.
            run_go = (start_i || go_q) && !key_wr_i && !st_wr_i;
            if (run_go)
            begin
               dec_d = decrypt_i;
               wk_d = key_q;
               rcon_d = RCON_FIRST;
               ph_d = '0;
               cyc_d = '0;
               kptr_d = '0;
               wptr_d = '0;
               rptr_d = '0;
               done_d = 1'b0;
               irq_d = 1'b0;
               if (decrypt_i)
               begin
                  rnd_d = '0;
                  fsm_d = ST_KEXP;
               end
               else
               begin
                  st_d = st_q ^ key_q;
                  rnd_d = FIRST_ROUND;
                  fsm_d = ST_ROUND;
               end
            end
         end
         ST_KEXP:
         begin
            cyc_d = cyc_q + 1'b1;
            ph_d = ph_q + 1'b1;
            if (ph_q <= PH_KEY_LAST)
               sw_d[ph_q[1:0]] = key_sub;
            else
            begin
               ph_d = '0;
               wk_d = nk;
               rcon_d = rc_step;
               rnd_d = rnd_q + 1'b1;
               if (rnd_q == DEC_START_ROUND)
               begin
                  st_d = st_q ^ nk;
                  rcon_d = RCON_LAST;
                  rnd_d = DEC_START_ROUND;
                  fsm_d = ST_ROUND;
               end
            end
         end
         ST_ROUND:
         begin
            cyc_d = cyc_q + 1'b1;
            ph_d = ph_q + 1'b1;
            if (ph_q < PH_ROUND_APPLY)
            begin
               st_d[ph_q[PTR_W-1:0]] = st_sub;
               if (ph_q <= PH_KEY_LAST)
                  sw_d[ph_q[1:0]] = key_sub;
            end
            else
            begin
               ph_d = '0;
               wk_d = nk;
               rcon_d = rc_step;
               st_d = sh ^ (dec_q ? nk : '0);
               for (int c = 0; c < 4; c++)
               begin
                  if (dec_q && rnd_q != '0)
                     st_d[4 * c +: 4] = abe_mix(st_d[4 * c +: 4], 1'b1);
                  else if (!dec_q && rnd_q != LAST_ROUND)
                     st_d[4 * c +: 4] = abe_mix(st_d[4 * c +: 4], 1'b0);
               end
               if (!dec_q)
                  st_d = st_d ^ nk;
               if (dec_q)
               begin
                  rnd_d = rnd_q - 1'b1;
                  if (rnd_q == '0)
                     fsm_d = ST_WAIT;
               end
               else
               begin
                  rnd_d = rnd_q + 1'b1;
                  if (rnd_q == LAST_ROUND)
                     fsm_d = ST_WAIT;
               end
            end
         end
         ST_WAIT:
         begin
            // The result is held back until the fixed run length has elapsed.
            cyc_d = cyc_q + 1'b1;
            if (cyc_q == RUN_CYCLES - 1'b1)
            begin
               fsm_d = ST_IDLE;
               done_d = 1'b1;
               irq_d = irq_en_i;
               trig_d = 1'b1;
            end
         end
      endcase
      // Busy is registered from the next state so that the port comes straight from a flop.
      busy_d = (fsm_d != ST_IDLE);
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         fsm_q <= ST_IDLE;
         st_q <= '0;
         key_q <= '0;
         wk_q <= '0;
         sw_q <= '0;
         rcon_q <= RCON_FIRST;
         ph_q <= '0;
         rnd_q <= '0;
         cyc_q <= '0;
         kptr_q <= '0;
         wptr_q <= '0;
         rptr_q <= '0;
         dec_q <= 1'b0;
         go_q <= 1'b0;
         done_q <= 1'b0;
         irq_q <= 1'b0;
         trig_q <= 1'b0;
         busy_q <= 1'b0;
         rdata_q <= 8'h00;
      end
      else if (ce_i)
      begin
         fsm_q <= fsm_d;
         st_q <= st_d;
         key_q <= key_d;
         wk_q <= wk_d;
         sw_q <= sw_d;
         rcon_q <= rcon_d;
         ph_q <= ph_d;
         rnd_q <= rnd_d;
         cyc_q <= cyc_d;
         kptr_q <= kptr_d;
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         dec_q <= dec_d;
         go_q <= go_d;
         done_q <= done_d;
         irq_q <= irq_d;
         trig_q <= trig_d;
         busy_q <= busy_d;
         rdata_q <= rdata_d;
      end
   end

   always_comb
   begin
      st_rdata_o = rdata_q;
      busy_o = busy_q;
      done_o = done_q;
      irq_o = irq_q;
      dma_trig_o = trig_q;
   end
endmodule

//--- abe_engine_properties.sv
// Concurrent checks on the block engine, seeing only its top-level ports.
// Assumes the single clock clk_sys_i and the synchronous active-high reset rst_i.
`timescale 1ns/1ps

module abe_engine_properties
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic decrypt_i,
   input wire logic xor_load_i,
   input wire logic auto_start_i,
   input wire logic irq_en_i,
   input wire logic start_i,
   input wire logic key_wr_i,
   input wire logic [abe_pkg::BYTE_W-1:0] key_wdata_i,
   input wire logic st_wr_i,
   input wire logic [abe_pkg::BYTE_W-1:0] st_wdata_i,
   input wire logic st_rd_i,
   input wire logic [abe_pkg::BYTE_W-1:0] st_rdata_o,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic irq_o,
   input wire logic dma_trig_o
);
   import abe_pkg::*;

   // ********************************
   // Run length counter
   // ********************************
   logic [CYC_W-1:0] run_cnt_q;
   logic [CYC_W-1:0] run_cnt_d;

   // A counter keeps the long run length out of any repetition operator.
   always_comb
   begin
      run_cnt_d = run_cnt_q;
      if (rst_i || !busy_o)
         run_cnt_d = '0;
      else if (ce_i)
         run_cnt_d = run_cnt_q + 1'b1;
   end

   always_ff @(posedge clk_sys_i)
   begin
      run_cnt_q <= run_cnt_d;
   end

   // ********************************
   // Properties
   // ********************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   property p_run_len;
      $rose(done_o) |-> $past(busy_o) && run_cnt_q == RUN_CYCLES;
   endproperty
   a_run_len: assert property (p_run_len)
      else $error("run did not last the fixed cycle count");

   property p_run_bound;
      busy_o |-> run_cnt_q < RUN_CYCLES;
   endproperty
   a_run_bound: assert property (p_run_bound)
      else $error("run went on past the fixed cycle count");

   property p_done_idle;
      done_o |-> !busy_o;
   endproperty
   a_done_idle: assert property (p_done_idle)
      else $error("done shown while a run is in progress");

   property p_dma_on_done;
      $rose(done_o) |-> dma_trig_o;
   endproperty
   a_dma_on_done: assert property (p_dma_on_done)
      else $error("no transfer trigger at completion");

   property p_dma_pulse;
      dma_trig_o && ce_i |=> !dma_trig_o;
   endproperty
   a_dma_pulse: assert property (p_dma_pulse)
      else $error("transfer trigger longer than one cycle");

   property p_irq_level;
      $rose(done_o) |-> irq_o == $past(irq_en_i);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt does not follow its enable at completion");

   property p_irq_only_done;
      irq_o |-> done_o;
   endproperty
   a_irq_only_done: assert property (p_irq_only_done)
      else $error("interrupt raised without completion");

   property p_start_clears;
      ce_i && start_i && !busy_o && !key_wr_i && !st_wr_i |=> busy_o && !done_o && !irq_o;
   endproperty
   a_start_clears: assert property (p_start_clears)
      else $error("start did not begin a run and clear done");

   property p_no_self_start;
      ce_i && !busy_o && !start_i && !auto_start_i |=> !busy_o;
   endproperty
   a_no_self_start: assert property (p_no_self_start)
      else $error("run began without any start request");

   property p_rd_hold;
      !done_o |=> $stable(st_rdata_o);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data changed before the result was ready");
endmodule

//--- tb_top.sv
// Self-checking bench for the block engine: known-answer runs, XOR load and automatic start.
// Assumes abe_sbox.sv, abe_engine.sv and the checker file are compiled first.
`timescale 1ns/1ps

module tb_top;
   import abe_pkg::*;

   // ********************************
   // Stimulus signals and counters
   // ********************************
   localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
   localparam logic [127:0] PLAIN = 128'h00112233445566778899aabbccddeeff;
   localparam logic [127:0] CIPHER = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
   localparam logic [127:0] MASK = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic decrypt_i = 1'b0;
   logic xor_load_i = 1'b0;
   logic auto_start_i = 1'b0;
   logic irq_en_i = 1'b0;
   logic start_i = 1'b0;
   logic key_wr_i = 1'b0;
   logic [BYTE_W-1:0] key_wdata_i = 8'h00;
   logic st_wr_i = 1'b0;
   logic [BYTE_W-1:0] st_wdata_i = 8'h00;
   logic st_rd_i = 1'b0;
   logic [BYTE_W-1:0] st_rdata_o;
   logic busy_o;
   logic done_o;
   logic irq_o;
   logic dma_trig_o;
   int errors = 0;
   int samples_checked = 0;

   abe_engine dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .decrypt_i(decrypt_i),
      .xor_load_i(xor_load_i), .auto_start_i(auto_start_i), .irq_en_i(irq_en_i),
      .start_i(start_i), .key_wr_i(key_wr_i), .key_wdata_i(key_wdata_i), .st_wr_i(st_wr_i),
      .st_wdata_i(st_wdata_i), .st_rd_i(st_rd_i), .st_rdata_o(st_rdata_o), .busy_o(busy_o),
      .done_o(done_o), .irq_o(irq_o), .dma_trig_o(dma_trig_o));

   initial
   begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   // ********************************
   // Shared tasks
   // ********************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Byte 0 is the leftmost byte of the 128-bit value; strobes run back to back.
   task automatic load(input logic to_key, input logic [127:0] v);
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clk_sys_i);
         key_wr_i <= to_key;
         st_wr_i <= !to_key;
         key_wdata_i <= v[127 - 8 * i -: 8];
         st_wdata_i <= v[127 - 8 * i -: 8];
      end
      @(posedge clk_sys_i);
      key_wr_i <= 1'b0;
      st_wr_i <= 1'b0;
   endtask

   // With by_start low the run must begin on its own after the last state byte.
   task automatic run(input logic by_start, input logic exp_irq);
      int n;
      @(posedge clk_sys_i);
      start_i <= by_start;
      #1;
      n = 0;
      // An automatic start may already have been taken at the edge just passed.
      while (busy_o !== 1'b1 && n < 40)
      begin
         @(posedge clk_sys_i);
         start_i <= 1'b0;
         #1;
         n++;
      end
      check(16'(busy_o), 16'h0001, "run begun");
      check(16'(done_o), 16'h0000, "done after start");
      check(16'(irq_o), 16'h0000, "irq after start");
      n = 0;
      do
      begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end while (done_o !== 1'b1 && n < 400);
      check(16'(n), 16'(RUN_CYCLES), "run length");
      check(16'(busy_o), 16'h0000, "busy at completion");
      check(16'(dma_trig_o), 16'h0001, "trigger at completion");
      check(16'(irq_o), 16'(exp_irq), "irq at completion");
      @(posedge clk_sys_i);
      #1;
      check(16'(dma_trig_o), 16'h0000, "trigger length");
      check(16'(irq_o), 16'(exp_irq), "irq held");
   endtask

   task automatic read_out(input logic [127:0] exp);
      @(posedge clk_sys_i);
      st_rd_i <= 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clk_sys_i);
         st_rd_i <= (i < 15);
         #1;
         check(16'(st_rdata_o), 16'(exp[127 - 8 * i -: 8]), "result byte");
      end
   endtask

   // ********************************
   // Scenarios
   // ********************************
   task automatic sc_encrypt;
      @(posedge clk_sys_i);
      decrypt_i <= 1'b0;
      irq_en_i <= 1'b1;
      load(1'b1, KEY);
      load(1'b0, PLAIN);
      run(1'b1, 1'b1);
      read_out(CIPHER);
   endtask

   task automatic sc_decrypt;
      @(posedge clk_sys_i);
      decrypt_i <= 1'b1;
      irq_en_i <= 1'b0;
      load(1'b0, CIPHER);
      run(1'b1, 1'b0);
      read_out(PLAIN);
   endtask

   // The masked block only becomes the plaintext if the second pass combines by XOR.
   task automatic sc_xor_auto;
      @(posedge clk_sys_i);
      decrypt_i <= 1'b0;
      irq_en_i <= 1'b1;
      load(1'b0, PLAIN ^ MASK);
      @(posedge clk_sys_i);
      xor_load_i <= 1'b1;
      auto_start_i <= 1'b1;
      load(1'b0, MASK);
      run(1'b0, 1'b1);
      @(posedge clk_sys_i);
      xor_load_i <= 1'b0;
      auto_start_i <= 1'b0;
      read_out(CIPHER);
   endtask

   // A frozen engine must ignore a start request and keep its completed result.
   task automatic sc_ce_hold;
      @(posedge clk_sys_i);
      ce_i <= 1'b0;
      start_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1;
      check(16'(busy_o), 16'h0000, "start while frozen");
      check(16'(done_o), 16'h0001, "done while frozen");
      @(posedge clk_sys_i);
      ce_i <= 1'b1;
      start_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1;
      check(16'(busy_o), 16'h0000, "no start after thaw");
   endtask

   initial
   begin
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      sc_encrypt();
      sc_decrypt();
      sc_xor_auto();
      sc_ce_hold();
      stop_test();
   end

   initial
   begin
      repeat (4000) @(posedge clk_sys_i);
      errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule

bind abe_engine abe_engine_properties chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
   .decrypt_i(decrypt_i), .xor_load_i(xor_load_i), .auto_start_i(auto_start_i),
   .irq_en_i(irq_en_i), .start_i(start_i), .key_wr_i(key_wr_i), .key_wdata_i(key_wdata_i),
   .st_wr_i(st_wr_i), .st_wdata_i(st_wdata_i), .st_rd_i(st_rd_i), .st_rdata_o(st_rdata_o),
   .busy_o(busy_o), .done_o(done_o), .irq_o(irq_o), .dma_trig_o(dma_trig_o));
